// ==== include/switch_aux_map.svh ====
`ifndef SWITCH_AUX_MAP_SVH
`define SWITCH_AUX_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_TERM 8'h03
`define OFF_AUX 8'h04
`define OFF_HP_LEN 8'h05
`define OFF_HP_OVR 8'h06
`define OFF_DROP_CTRL 8'h07
`define OFF_REPL 8'h0E
`define OFF_KEY 8'h0F
`define OFF_DROP_STAT 8'h10
`define OFF_STEP 8'hFE
`define OFF_PART 8'hFF
// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define RST_TERM 8'h0F
`define RST_AUX 8'h07
`define RST_HP_LEN 8'h05
`define RST_HP_OVR 8'h00
`define RST_DROP_CTRL 8'h00
`define RST_REPL 8'h00
`define RST_KEY 8'h00
`define RST_DROP_STAT 8'h00
`define WMASK_AUX 8'h07
`define WMASK_HP_OVR 8'h1F
`define WMASK_DROP_CTRL 8'h37
`define WMASK_REPL 8'h01
// ----------------------------------------
// fields and codes
// ----------------------------------------
`define TERM_SRC_F 7:4
`define TERM_MASK_F 3:0
`define TERM_SRC_MANUAL 4'hF
`define AUX_DDC_BIT 1
`define AUX_CEC_BIT 0
`define HP_SRC_BIT 4
`define HP_MASK_F 3:0
`define DROP_THR_F 5:4
`define DROP_SQUELCH_BIT 2
`define DROP_EN_BIT 0
`define REPL_BIT 0
`define UNLOCK_VALUE 8'h96
`define DEV_ADDR_HI 5'h12
// ----------------------------------------
// timing
// ----------------------------------------
`define REF_CLK_KHZ 40000
`define HP_STEP_MS 24
`define HP_STEP_CYCLES (`HP_STEP_MS * `REF_CLK_KHZ)
`define HP_DIV_W 20
`endif

// ==== include/switch_aux_pkg.sv ====
package switch_aux_pkg;
    typedef enum logic [3:0] {
        I2C_IDLE, I2C_DEV, I2C_DEV_ACK, I2C_PTR, I2C_PTR_ACK,
        I2C_WDATA, I2C_WDATA_ACK, I2C_TX, I2C_MACK
    } i2c_state_e;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } line_event_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } line_sample_s;

    typedef struct packed {
        logic [7:0] term;
        logic [7:0] aux;
        logic [7:0] hp_len;
        logic [7:0] hp_ovr;
        logic [7:0] drop_ctrl;
        logic [7:0] repl;
        logic [7:0] key;
        logic [7:0] drop_stat;
    } reg_bank_s;

    typedef struct packed {
        logic [3:0] term_enable;
        logic display_data_buf_en;
        logic consumer_control_buf_en;
        logic auto_squelch_en;
        logic signal_drop_detect_en;
        logic [1:0] signal_drop_threshold;
        logic replicator_disable;
        logic eeprom_write_allowed;
        logic [3:0] hotplug_oe;
    } ctl_out_s;

    typedef struct packed {
        i2c_state_e st;
        logic [3:0] cnt;
        logic [7:0] sr;
        logic [7:0] ptr;
        logic rw;
        logic nack;
        reg_bank_s regs;
        ctl_out_s ctl;
    } top_state_s;

    typedef struct packed {
        logic [19:0] div;
        logic [7:0] steps;
        logic active;
    } pulse_state_s;
endpackage

// ==== rtl/i2c_line_events.sv ====
module i2c_line_events (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded events
    output switch_aux_pkg::line_event_s ev
);
    switch_aux_pkg::line_sample_s s_reg;
    switch_aux_pkg::line_sample_s s_next;

    always_comb
    begin
        s_next.scl = scl_in;
        s_next.sda = sda_in;
        ev.start = s_reg.scl & scl_in & s_reg.sda & ~sda_in;
        ev.stop = s_reg.scl & scl_in & ~s_reg.sda & sda_in;
        ev.scl_rise = ~s_reg.scl & scl_in;
        ev.scl_fall = s_reg.scl & ~scl_in;
        ev.sda = sda_in;
    end

    // idle bus is high on both lines
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '{scl: 1'b1, sda: 1'b1};
        else
            s_reg <= s_next;
    end
endmodule // i2c_line_events

// ==== rtl/hotplug_pulser.sv ====
`include "switch_aux_map.svh"
module hotplug_pulser #(
    parameter int unsigned STEP_CYCLES = `HP_STEP_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // request
    input wire logic trigger,
    input wire logic [7:0] pulse_len,
    // pulse state
    output logic active
);
    switch_aux_pkg::pulse_state_s s_reg;
    switch_aux_pkg::pulse_state_s s_next;
    logic step_tick;

    // divider only runs while a pulse is in flight
    always_comb
    begin
        s_next = s_reg;
        step_tick = s_reg.active && s_reg.div == `HP_DIV_W'(STEP_CYCLES - 1);
        if (trigger)
        begin
            s_next.div = '0;
            s_next.steps = pulse_len;
            s_next.active = pulse_len != 8'h00;
        end
        else if (step_tick)
        begin
            s_next.div = '0;
            s_next.steps = s_reg.steps - 8'h01;
            s_next.active = s_reg.steps != 8'h01;
        end
        else if (s_reg.active)
            s_next.div = s_reg.div + `HP_DIV_W'(1);
        active = s_reg.active;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
endmodule // hotplug_pulser

// ==== rtl/switch_aux_regs.sv ====
// Notes on behaviour
// - termination source 0000 means automatic, 1111 means manual control
// - manual termination: mask bit n enables input n, A at bit 0
// - manual termination with zero mask turns every termination off
// - aux enable bit 1 switches the display data channel buffer
// - aux enable bit 0 switches the consumer control line buffer
// - automatic hot-plug low pulse lasts length field times 24 ms
// - hot-plug source bit clear: outputs pulse automatically on channel switch
// - hot-plug source bit set: outputs follow the manual mask directly
// - manual mask zero leaves all hot-plug outputs released, pulled high
// - manual mask bit n pulls hot-plug output n low, A at bit 0
// - signal-loss control bit 2 enables automatic output squelch
// - signal-loss control bit 0 enables detector; bits 5:4 pick threshold
// - replication bit zero enables replicator loading from external eeprom
// - replication bit one disables replicator, lets host write edid sram
// - unlock key 0x96 lifts eeprom write protection
// - unlock key 0x00 keeps eeprom write protection active
// - signal-loss status shows one bit per input, A at bit 0
// - signal-loss status reads zero while all inputs are active
// - i2c slave at address 10010 plus two strap bits
`include "switch_aux_map.svh"
module switch_aux_regs #(
    parameter int unsigned HP_STEP_CYCLES = `HP_STEP_CYCLES,
    // identity values are arbitrary
    parameter logic [7:0] SILICON_STEP = 8'h01,
    parameter logic [7:0] PART_NUMBER = 8'h5A
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // serial host port
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_strap,
    // device status
    input wire logic [3:0] signal_drop_raw,
    input wire logic [3:0] auto_term_on,
    input wire logic channel_switch,
    // control outputs
    output logic [3:0] term_enable,
    output logic display_data_buf_en,
    output logic consumer_control_buf_en,
    output logic auto_squelch_en,
    output logic signal_drop_detect_en,
    output logic [1:0] signal_drop_threshold,
    output logic replicator_disable,
    output logic eeprom_write_allowed,
    // hot-plug pins, open drain
    input wire logic [3:0] hotplug_in,
    output logic [3:0] hotplug_out,
    output logic [3:0] hotplug_oe
);
    localparam switch_aux_pkg::top_state_s RESET_STATE = '{
        st: switch_aux_pkg::I2C_IDLE,
        cnt: 4'h0,
        sr: 8'h00,
        ptr: 8'h00,
        rw: 1'b0,
        nack: 1'b0,
        regs: '{term: `RST_TERM, aux: `RST_AUX, hp_len: `RST_HP_LEN,
            hp_ovr: `RST_HP_OVR, drop_ctrl: `RST_DROP_CTRL, repl: `RST_REPL,
            key: `RST_KEY, drop_stat: `RST_DROP_STAT},
        ctl: '{display_data_buf_en: 1'b1, consumer_control_buf_en: 1'b1,
            default: '0}
    };

    switch_aux_pkg::top_state_s s_reg;
    switch_aux_pkg::top_state_s s_next;
    switch_aux_pkg::line_event_s ev;
    logic hp_active;
    logic hp_manual;

    // ----------------------------------------
    // register access
    // ----------------------------------------
    function automatic logic [7:0] read_value(switch_aux_pkg::reg_bank_s r,
                                              logic [7:0] a);
        case (a)
            `OFF_TERM: read_value = r.term;
            `OFF_AUX: read_value = r.aux;
            `OFF_HP_LEN: read_value = r.hp_len;
            `OFF_HP_OVR: read_value = r.hp_ovr;
            `OFF_DROP_CTRL: read_value = r.drop_ctrl;
            `OFF_DROP_STAT: read_value = r.drop_stat;
            `OFF_STEP: read_value = SILICON_STEP;
            `OFF_PART: read_value = PART_NUMBER;
            default: read_value = 8'h00;
        endcase
    endfunction

    function automatic switch_aux_pkg::reg_bank_s write_reg(
        switch_aux_pkg::reg_bank_s r, logic [7:0] a, logic [7:0] d);
        switch_aux_pkg::reg_bank_s w;
        w = r;
        // masks clear unused bits except aux bit 2 and drop_ctrl bit 1; status and ids ignore writes
        case (a)
            `OFF_TERM: w.term = d;
            `OFF_AUX: w.aux = d & `WMASK_AUX;
            `OFF_HP_LEN: w.hp_len = d;
            `OFF_HP_OVR: w.hp_ovr = d & `WMASK_HP_OVR;
            `OFF_DROP_CTRL: w.drop_ctrl = d & `WMASK_DROP_CTRL;
            `OFF_REPL: w.repl = d & `WMASK_REPL;
            `OFF_KEY: w.key = d;
            default: w = r;
        endcase
        return w;
    endfunction

    // ----------------------------------------
    // submodules
    // ----------------------------------------
    i2c_line_events u_events (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    assign hp_manual = s_reg.regs.hp_ovr[`HP_SRC_BIT];

    // a switch in manual mode does not arm the pulse
    hotplug_pulser #(
        .STEP_CYCLES(HP_STEP_CYCLES)
    ) u_pulser (
        .ref_clk(ref_clk),
        .rst(rst),
        .trigger(channel_switch && !hp_manual),
        .pulse_len(s_reg.regs.hp_len),
        .active(hp_active)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.regs.drop_stat = {4'h0, signal_drop_raw
            & {4{s_reg.regs.drop_ctrl[`DROP_EN_BIT]}}};

        if (s_reg.regs.term[`TERM_SRC_F] == `TERM_SRC_MANUAL)
            s_next.ctl.term_enable = s_reg.regs.term[`TERM_MASK_F];
        else
            s_next.ctl.term_enable = auto_term_on;
        s_next.ctl.display_data_buf_en = s_reg.regs.aux[`AUX_DDC_BIT];
        s_next.ctl.consumer_control_buf_en = s_reg.regs.aux[`AUX_CEC_BIT];
        s_next.ctl.auto_squelch_en = s_reg.regs.drop_ctrl[`DROP_SQUELCH_BIT];
        s_next.ctl.signal_drop_detect_en = s_reg.regs.drop_ctrl[`DROP_EN_BIT];
        s_next.ctl.signal_drop_threshold = s_reg.regs.drop_ctrl[`DROP_THR_F];
        s_next.ctl.replicator_disable = s_reg.regs.repl[`REPL_BIT];
        s_next.ctl.eeprom_write_allowed = s_reg.regs.key == `UNLOCK_VALUE;
        if (hp_manual)
            s_next.ctl.hotplug_oe = s_reg.regs.hp_ovr[`HP_MASK_F];
        else
            s_next.ctl.hotplug_oe = {4{hp_active}};

        // start and stop win over any byte in progress
        if (ev.stop)
            s_next.st = switch_aux_pkg::I2C_IDLE;
        else if (ev.start)
        begin
            s_next.st = switch_aux_pkg::I2C_DEV;
            s_next.cnt = 4'h0;
        end
        else
        begin
            unique case (s_reg.st)
                switch_aux_pkg::I2C_IDLE:
                    s_next.st = switch_aux_pkg::I2C_IDLE;
                switch_aux_pkg::I2C_DEV,
                switch_aux_pkg::I2C_PTR,
                switch_aux_pkg::I2C_WDATA:
                begin
                    if (ev.scl_rise)
                    begin
                        s_next.sr = {s_reg.sr[6:0], ev.sda};
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end
                    else if (ev.scl_fall && s_reg.cnt == 4'h8)
                    begin
                        s_next.cnt = 4'h0;
                        if (s_reg.st == switch_aux_pkg::I2C_DEV)
                        begin
                            // a foreign address drops us until the next start
                            if (s_reg.sr[7:1] == {`DEV_ADDR_HI, addr_strap})
                            begin
                                s_next.rw = s_reg.sr[0];
                                s_next.st = switch_aux_pkg::I2C_DEV_ACK;
                            end
                            else
                                s_next.st = switch_aux_pkg::I2C_IDLE;
                        end
                        else if (s_reg.st == switch_aux_pkg::I2C_PTR)
                        begin
                            s_next.ptr = s_reg.sr;
                            s_next.st = switch_aux_pkg::I2C_PTR_ACK;
                        end
                        else
                        begin
                            s_next.regs = write_reg(s_next.regs, s_reg.ptr, s_reg.sr);
                            s_next.ptr = s_reg.ptr + 8'h01;
                            s_next.st = switch_aux_pkg::I2C_WDATA_ACK;
                        end
                    end
                end
                switch_aux_pkg::I2C_DEV_ACK,
                switch_aux_pkg::I2C_PTR_ACK,
                switch_aux_pkg::I2C_WDATA_ACK:
                begin
                    if (ev.scl_fall)
                    begin
                        s_next.cnt = 4'h0;
                        if (s_reg.st == switch_aux_pkg::I2C_DEV_ACK && s_reg.rw)
                        begin
                            s_next.sr = read_value(s_reg.regs, s_reg.ptr);
                            s_next.ptr = s_reg.ptr + 8'h01;
                            s_next.st = switch_aux_pkg::I2C_TX;
                        end
                        else if (s_reg.st == switch_aux_pkg::I2C_DEV_ACK)
                            s_next.st = switch_aux_pkg::I2C_PTR;
                        else
                            s_next.st = switch_aux_pkg::I2C_WDATA;
                    end
                end
                switch_aux_pkg::I2C_TX:
                begin
                    if (ev.scl_fall && s_reg.cnt == 4'h7)
                    begin
                        s_next.cnt = 4'h0;
                        s_next.st = switch_aux_pkg::I2C_MACK;
                    end
                    else if (ev.scl_fall)
                    begin
                        s_next.sr = {s_reg.sr[6:0], 1'b0};
                        s_next.cnt = s_reg.cnt + 4'h1;
                    end
                end
                switch_aux_pkg::I2C_MACK:
                begin
                    if (ev.scl_rise)
                        s_next.nack = ev.sda;
                    else if (ev.scl_fall && s_reg.nack)
                        s_next.st = switch_aux_pkg::I2C_IDLE;
                    else if (ev.scl_fall)
                    begin
                        s_next.sr = read_value(s_reg.regs, s_reg.ptr);
                        s_next.ptr = s_reg.ptr + 8'h01;
                        s_next.st = switch_aux_pkg::I2C_TX;
                    end
                end
                default:
                    s_next.st = switch_aux_pkg::I2C_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_reg <= RESET_STATE;
        else
            s_reg <= s_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // sda is only ever pulled low, never driven high
    assign sda_out = 1'b0;
    assign sda_oe = s_reg.st == switch_aux_pkg::I2C_DEV_ACK
        || s_reg.st == switch_aux_pkg::I2C_PTR_ACK
        || s_reg.st == switch_aux_pkg::I2C_WDATA_ACK
        || (s_reg.st == switch_aux_pkg::I2C_TX && !s_reg.sr[7]);
    assign term_enable = s_reg.ctl.term_enable;
    assign display_data_buf_en = s_reg.ctl.display_data_buf_en;
    assign consumer_control_buf_en = s_reg.ctl.consumer_control_buf_en;
    assign auto_squelch_en = s_reg.ctl.auto_squelch_en;
    assign signal_drop_detect_en = s_reg.ctl.signal_drop_detect_en;
    assign signal_drop_threshold = s_reg.ctl.signal_drop_threshold;
    assign replicator_disable = s_reg.ctl.replicator_disable;
    assign eeprom_write_allowed = s_reg.ctl.eeprom_write_allowed;
    // pins only ever pull low; hotplug_in is left for board-level sensing
    assign hotplug_out = 4'h0;
    assign hotplug_oe = s_reg.ctl.hotplug_oe;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence dev_addr_hit;
        s_reg.st == switch_aux_pkg::I2C_DEV && ev.scl_fall && !ev.stop && !ev.start
            && s_reg.cnt == 4'h8 && s_reg.sr[7:1] == {`DEV_ADDR_HI, addr_strap};
    endsequence

    sequence data_byte_in;
        s_reg.st == switch_aux_pkg::I2C_WDATA && ev.scl_fall && !ev.stop && !ev.start
            && s_reg.cnt == 4'h8;
    endsequence

    sequence wo_read_load;
        s_reg.st == switch_aux_pkg::I2C_DEV_ACK && s_reg.rw && ev.scl_fall
            && !ev.stop && !ev.start
            && (s_reg.ptr == `OFF_REPL || s_reg.ptr == `OFF_KEY);
    endsequence

    dev_addr_ack_a: assert property (dev_addr_hit |=> sda_oe && !sda_out)
        else $error("own address not acknowledged");
    len_write_a: assert property (data_byte_in ##0 s_reg.ptr == `OFF_HP_LEN
        |=> s_reg.regs.hp_len == $past(s_reg.sr) && sda_oe)
        else $error("pulse length byte not stored or acknowledged");
    wo_read_zero_a: assert property (wo_read_load |=> s_reg.sr == 8'h00)
        else $error("write-only register read back nonzero");
    // the edge that leaves reset still loads the reset enables, so start one later
    term_select_a: assert property (!rst |=> term_enable
        == ($past(s_reg.regs.term[`TERM_SRC_F]) == `TERM_SRC_MANUAL
        ? $past(s_reg.regs.term[`TERM_MASK_F]) : $past(auto_term_on)))
        else $error("termination enables wrong for source");
    aux_buffers_a: assert property (##1 {display_data_buf_en, consumer_control_buf_en}
        == $past(s_reg.regs.aux[1:0]))
        else $error("aux buffer enables do not follow register");
    hp_manual_a: assert property (hp_manual ##1 hp_manual
        |-> hotplug_oe == $past(s_reg.regs.hp_ovr[`HP_MASK_F]) && hotplug_out == 4'h0)
        else $error("manual hot-plug pins do not follow mask");
    hp_auto_pulse_a: assert property (!hp_manual && channel_switch
        && s_reg.regs.hp_len != 8'h00 ##1 (!hp_manual)[*2] |-> hotplug_oe == 4'hF)
        else $error("hot-plug pulse did not start");
    hp_auto_idle_a: assert property (!hp_manual && !hp_active |=> hotplug_oe == 4'h0)
        else $error("hot-plug pins pulled without a pulse");
    drop_ctrl_a: assert property (##1 {auto_squelch_en, signal_drop_detect_en,
        signal_drop_threshold} == {$past(s_reg.regs.drop_ctrl[`DROP_SQUELCH_BIT]),
        $past(s_reg.regs.drop_ctrl[`DROP_EN_BIT]), $past(s_reg.regs.drop_ctrl[`DROP_THR_F])})
        else $error("signal-loss controls do not follow register");
    replicator_a: assert property (##1 replicator_disable
        == $past(s_reg.regs.repl[`REPL_BIT]))
        else $error("replicator mode wrong");
    unlock_key_a: assert property (##1 eeprom_write_allowed
        == ($past(s_reg.regs.key) == `UNLOCK_VALUE))
        else $error("eeprom protection does not follow key");
    // gate is the register bit itself, not the output that lags it by a cycle
    drop_status_a: assert property (##1 s_reg.regs.drop_stat
        == {4'h0, $past(signal_drop_raw) & {4{$past(s_reg.regs.drop_ctrl[`DROP_EN_BIT])}}})
        else $error("signal-loss status wrong");
endmodule // switch_aux_regs

// ==== test/i2c_host_model.sv ====
module i2c_host_model (
    // clock
    input wire logic ref_clk,
    // bus lines, sda_low high while the host pulls the data line down
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // four cycles a level, so the slave's single-register edge detector always sees it
    task automatic step(input logic on_scl, input logic v);
        if (on_scl) scl <= v;
        else sda_low <= v;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b0);
    endtask
    task automatic bit_io(input logic b, output logic r);
        step(1'b0, !b);
        step(1'b1, 1'b1);
        r = sda;
        step(1'b1, 1'b0);
    endtask
    // ninth bit always released: slave ack on writes, host nack on reads
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
        logic [7:0] q;
        logic k1, k2, k3;
        start();
        byte_io({dev, 1'b0}, q, k1);
        byte_io(a, q, k2);
        byte_io(d, q, k3);
        stop();
        ok = k1 && k2 && k3;
    endtask
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] q);
        logic [7:0] t;
        logic k;
        start();
        byte_io({dev, 1'b0}, t, k);
        byte_io(a, t, k);
        start();
        byte_io({dev, 1'b1}, t, k);
        byte_io(8'hFF, q, k);
        stop();
    endtask
endmodule // i2c_host_model

// ==== test/switch_aux_control_registers_test.sv ====
module switch_aux_control_registers_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0] DEV = 7'h4A;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] signal_drop_raw = 4'h0;
    logic [3:0] auto_term_on = 4'hA;
    logic channel_switch = 1'b0;
    logic scl, sda_low, sda_oe, ddc, cec, sq, det, rdis, ee, ok;
    logic [3:0] term_enable, hotplug_oe;
    logic [1:0] thr;
    logic [7:0] q;
    wire sda = !(sda_low || sda_oe);
    int failures = 0;
    int check_count = 0;
    always #12.5 ref_clk = ~ref_clk;
    switch_aux_regs #(.HP_STEP_CYCLES(8), .SILICON_STEP(8'h3C), .PART_NUMBER(8'hA5))
        u_switch_aux_regs (
        .ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
        .addr_strap(2'b10), .signal_drop_raw(signal_drop_raw), .auto_term_on(auto_term_on),
        .channel_switch(channel_switch), .term_enable(term_enable), .display_data_buf_en(ddc),
        .consumer_control_buf_en(cec), .auto_squelch_en(sq), .signal_drop_detect_en(det),
        .signal_drop_threshold(thr), .replicator_disable(rdis), .eeprom_write_allowed(ee),
        .hotplug_in(4'hF), .hotplug_out(), .hotplug_oe(hotplug_oe));
    i2c_host_model u_i2c_host_model (.ref_clk(ref_clk), .scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_i2c_host_model.write_reg(DEV, a, d, ok);
        check({7'h0, ok}, 8'h01);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_i2c_host_model.read_reg(DEV, a, q);
        check(q, e);
    endtask
    task automatic t_defaults();
        logic [7:0] adr [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0E, 8'h0F, 8'h10};
        logic [7:0] dft [8] = '{8'h0F, 8'h07, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] tv [5] = '{8'hF1, 8'hF8, 8'hFF, 8'hF0, 8'h05};
        logic [3:0] te [5] = '{4'h1, 4'h8, 4'hF, 4'h0, 4'hA};
        foreach (adr[i]) rd_chk(adr[i], dft[i]);
        check({4'h0, term_enable}, 8'h0A);
        foreach (tv[i])
        begin
            wr(8'h03, tv[i]);
            check({4'h0, term_enable}, {4'h0, te[i]});
        end
        $display("defaults and termination done");
    endtask
    task automatic t_aux_wo();
        wr(8'h04, 8'h05);
        check({6'h0, ddc, cec}, 8'h01);
        wr(8'h04, 8'hFE);
        check({6'h0, ddc, cec}, 8'h02);
        rd_chk(8'h04, 8'h06);
        wr(8'h0E, 8'h01);
        check({7'h0, rdis}, 8'h01);
        rd_chk(8'h0E, 8'h00);
        wr(8'h0E, 8'h00);
        check({7'h0, rdis}, 8'h00);
        wr(8'h0F, 8'h96);
        check({7'h0, ee}, 8'h01);
        rd_chk(8'h0F, 8'h00);
        wr(8'h0F, 8'h00);
        check({7'h0, ee}, 8'h00);
        $display("aux and write-only done");
    endtask
    task automatic t_hotplug();
        logic [7:0] hv [4] = '{8'h10, 8'h11, 8'h18, 8'h1F};
        logic [3:0] he [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
        int n = 0;
        foreach (hv[i])
        begin
            wr(8'h06, hv[i]);
            check({4'h0, hotplug_oe}, {4'h0, he[i]});
        end
        wr(8'h06, 8'h00);
        wr(8'h05, 8'h03);
        channel_switch <= 1'b1;
        @(posedge ref_clk);
        channel_switch <= 1'b0;
        // sample mid-cycle, where the pins have settled
        repeat (40)
        begin
            @(negedge ref_clk);
            if (hotplug_oe === 4'hF) n++;
        end
        check(8'(n), 8'h18);
        $display("hot-plug done");
    endtask
    task automatic t_drop();
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h07, {2'b00, 2'(i), 4'h5});
            check({4'h0, sq, det, thr}, {4'h0, 2'b11, 2'(i)});
        end
        rd_chk(8'h07, 8'h35);
        signal_drop_raw <= 4'h9;
        rd_chk(8'h10, 8'h09);
        signal_drop_raw <= 4'h0;
        rd_chk(8'h10, 8'h00);
        wr(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h20, 8'h00);
        wr(8'hFE, 8'h00);
        rd_chk(8'hFE, 8'h3C);
        rd_chk(8'hFF, 8'hA5);
        u_i2c_host_model.write_reg(7'h4B, 8'h05, 8'h00, ok);
        check({7'h0, ok}, 8'h00);
        rd_chk(8'h05, 8'h03);
        $display("signal loss and addressing done");
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_defaults();
        t_aux_wo();
        t_hotplug();
        t_drop();
        close_out();
    end
endmodule // switch_aux_control_registers_test
